// ==== inc/sr_hold_pkg.sv ====
// Constants and types for the warm-reset self-refresh hold controller.
// ------------------------------------------------------------------
// ------------------------------------------------------------------
package sr_hold_pkg;

  // ----------------------------------------------------------------
  // Register map and fields.
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_REFRESH = 8'h00;
  localparam logic [7:0] REG_MISC = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int INTERVAL_W = 16;
  localparam logic [15:0] INTERVAL_RST = 16'h0c30;
  localparam int HOLD_EN_BIT = 6;
  localparam int HOLD_BIT = 5;
  localparam int ST_SR_BIT = 0;
  localparam int ST_WARM_BIT = 1;
  localparam int ST_DONE_BIT = 2;
  localparam int ST_BYPASS_BIT = 3;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int WARM_DURATION_NS = 20000;
  localparam int WARM_CYCLES = (WARM_DURATION_NS / CLK_PERIOD_NS) > 0 ?
    (WARM_DURATION_NS / CLK_PERIOD_NS) : 1;
  localparam int DUR_W = 12;

  // ----------------------------------------------------------------
  // SDRAM command carrier and controller states.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_NOP = 2'b00,
    OP_REF = 2'b01,
    OP_SRE = 2'b10,
    OP_SRX = 2'b11
  } op_t;

  typedef struct packed {
    logic cke;
    op_t op;
  } sdram_cmd_t;

  typedef enum logic {
    ST_ACTIVE = 1'b0,
    ST_SELFREF = 1'b1
  } ctl_state_t;

endpackage

// ==== rtl/refresh_timer.sv ====
// Periodic refresh interval counter.
`timescale 1ns/1ns
module refresh_timer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [15:0] interval_i,
  output logic fire_o
);
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic fire_ff;
  logic nxt_fire;

  // A zero interval stops refresh rather than firing every cycle.
  always_comb begin
    nxt_count = count_ff;
    nxt_fire = 1'b0;
    if (restart_i || !run_i || interval_i == 16'h0000) begin
      nxt_count = 16'h0000;
    end else if (count_ff >= interval_i - 16'h0001) begin
      nxt_count = 16'h0000;
      nxt_fire = 1'b1;
    end else begin
      nxt_count = count_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_ff <= 16'h0000;
      fire_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      fire_ff <= nxt_fire;
    end
  end

  assign fire_o = fire_ff;
endmodule

// ==== rtl/warm_duration_timer.sv ====
// Warm reset duration counter, started at each warm reset entry.
`timescale 1ns/1ns
module warm_duration_timer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  output logic done_o
);
  localparam logic [11:0] LAST =
    12'(sr_hold_pkg::WARM_CYCLES - 1);
  logic [11:0] count_ff;
  logic [11:0] nxt_count;
  logic done_ff;
  logic nxt_done;

  // Done holds until the next start so the exit decision can wait.
  always_comb begin
    nxt_count = count_ff;
    nxt_done = done_ff;
    if (start_i) begin
      nxt_count = 12'h000;
      nxt_done = 1'b0;
    end else if (!done_ff) begin
      if (count_ff == LAST) begin
        nxt_done = 1'b1;
      end else begin
        nxt_count = count_ff + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_ff <= 12'h000;
      done_ff <= 1'b1;
    end else begin
      count_ff <= nxt_count;
      done_ff <= nxt_done;
    end
  end

  assign done_o = done_ff;
endmodule

// ==== rtl/sr_hold_ctrl.sv ====
// Warm-reset self-refresh hold controller for an external DDR3 SDRAM.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
module sr_hold_ctrl (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic warm_reset_i,
  input wire logic clk_bypass_i,
  output sr_hold_pkg::sdram_cmd_t cmd_o,
  output logic clk_change_ok_o
);

  // ----------------------------------------------------------------
  // Register file.
  // ----------------------------------------------------------------
  logic [15:0] interval_ff;
  logic [15:0] nxt_interval;
  logic hold_en_ff;
  logic nxt_hold_en;
  logic hold_ff;
  logic nxt_hold;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  logic warm_q_ff;
  logic warm_rise;
  logic dur_done;
  logic refresh_fire;
  sr_hold_pkg::ctl_state_t state_ff;
  sr_hold_pkg::ctl_state_t nxt_state;
  sr_hold_pkg::sdram_cmd_t cmd_ff;
  sr_hold_pkg::sdram_cmd_t nxt_cmd;
  logic chg_ok_ff;
  logic nxt_chg_ok;
  logic exit_ok;
  logic restart_refresh;

  // Strobe decode for one register. The write path and the assertions
  // share it, so the two cannot drift apart.
  function automatic logic wr_hit(
    input logic wr,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return wr && (addr == target);
  endfunction

  assign warm_rise = warm_reset_i && !warm_q_ff;

  always_comb begin
    nxt_interval = interval_ff;
    nxt_hold_en = hold_en_ff;
    nxt_hold = hold_ff;
    if (wr_hit(wr_i, addr_i, sr_hold_pkg::REG_REFRESH)) begin
      nxt_interval = wdata_i[15:0];
    end
    if (wr_hit(wr_i, addr_i, sr_hold_pkg::REG_MISC)) begin
      nxt_hold_en = wdata_i[sr_hold_pkg::HOLD_EN_BIT];
      nxt_hold = wdata_i[sr_hold_pkg::HOLD_BIT];
    end
    // Arming the hold at warm reset entry wins over a same-cycle clear,
    // so a racing software write cannot release the memory early.
    if (warm_rise && nxt_hold_en) begin
      nxt_hold = 1'b1;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_i) begin
      unique case (addr_i)
        sr_hold_pkg::REG_REFRESH: begin
          nxt_rdata[15:0] = interval_ff;
        end
        sr_hold_pkg::REG_MISC: begin
          nxt_rdata[sr_hold_pkg::HOLD_EN_BIT] = hold_en_ff;
          nxt_rdata[sr_hold_pkg::HOLD_BIT] = hold_ff;
        end
        sr_hold_pkg::REG_STATUS: begin
          nxt_rdata[sr_hold_pkg::ST_SR_BIT] =
            (state_ff == sr_hold_pkg::ST_SELFREF);
          nxt_rdata[sr_hold_pkg::ST_WARM_BIT] = warm_q_ff;
          nxt_rdata[sr_hold_pkg::ST_DONE_BIT] = dur_done;
          nxt_rdata[sr_hold_pkg::ST_BYPASS_BIT] = clk_bypass_i;
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      interval_ff <= sr_hold_pkg::INTERVAL_RST;
      hold_en_ff <= 1'b0;
      hold_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      warm_q_ff <= 1'b0;
    end else begin
      interval_ff <= nxt_interval;
      hold_en_ff <= nxt_hold_en;
      hold_ff <= nxt_hold;
      rdata_ff <= nxt_rdata;
      warm_q_ff <= warm_reset_i;
    end
  end

  // ----------------------------------------------------------------
  // Timers.
  // ----------------------------------------------------------------
  warm_duration_timer u_dur (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .start_i(warm_rise),
    .done_o(dur_done)
  );

  // Refresh stops as soon as warm reset is seen, a cycle ahead of the
  // state change, so no refresh can slip out behind the entry command.
  refresh_timer u_ref (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .run_i(state_ff == sr_hold_pkg::ST_ACTIVE && !warm_reset_i),
    .restart_i(restart_refresh),
    .interval_i(interval_ff),
    .fire_o(refresh_fire)
  );

  // ----------------------------------------------------------------
  // Self-refresh sequencing.
  // ----------------------------------------------------------------
  // Exit needs the duration spent, warm reset released, no hold, and
  // the functional clock back; the bypass rate is below the memory's
  // legal range, so leaving self-refresh on it risks a hang.
  assign exit_ok = dur_done && !warm_reset_i && !hold_ff
    && !clk_bypass_i;

  always_comb begin
    nxt_state = state_ff;
    nxt_cmd.cke = cmd_ff.cke;
    nxt_cmd.op = sr_hold_pkg::OP_NOP;
    restart_refresh = 1'b0;
    unique case (state_ff)
      sr_hold_pkg::ST_ACTIVE: begin
        if (warm_rise) begin
          nxt_state = sr_hold_pkg::ST_SELFREF;
          nxt_cmd.op = sr_hold_pkg::OP_SRE;
          nxt_cmd.cke = 1'b0;
        end else if (refresh_fire) begin
          nxt_cmd.op = sr_hold_pkg::OP_REF;
        end
      end
      sr_hold_pkg::ST_SELFREF: begin
        // No refresh is sent here; the memory refreshes itself, which
        // is what makes the slow bypass clock harmless.
        if (exit_ok) begin
          nxt_state = sr_hold_pkg::ST_ACTIVE;
          nxt_cmd.op = sr_hold_pkg::OP_SRX;
          nxt_cmd.cke = 1'b1;
          restart_refresh = 1'b1;
        end
      end
    endcase
    nxt_chg_ok = (nxt_state == sr_hold_pkg::ST_SELFREF);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= sr_hold_pkg::ST_ACTIVE;
      cmd_ff <= '{cke: 1'b1, op: sr_hold_pkg::OP_NOP};
      chg_ok_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      chg_ok_ff <= nxt_chg_ok;
    end
  end

  assign rdata_o = rdata_ff;
  assign cmd_o = cmd_ff;
  assign clk_change_ok_o = chg_ok_ff;

  // ----------------------------------------------------------------
  // Refresh resume watch.
  // ----------------------------------------------------------------
  // Counts cycles from a self-refresh exit to the first refresh, so the
  // check below follows whatever interval software has programmed.
  logic resume_wait_ff;
  logic nxt_resume_wait;
  logic [15:0] resume_cnt_ff;
  logic [15:0] nxt_resume_cnt;

  always_comb begin
    nxt_resume_wait = resume_wait_ff;
    nxt_resume_cnt = resume_cnt_ff;
    if (cmd_ff.op == sr_hold_pkg::OP_SRX) begin
      nxt_resume_wait = 1'b1;
      nxt_resume_cnt = 16'h0000;
    end else if (cmd_ff.op == sr_hold_pkg::OP_REF || warm_reset_i
      || wr_hit(wr_i, addr_i, sr_hold_pkg::REG_REFRESH)) begin
      nxt_resume_wait = 1'b0;
    end else if (resume_wait_ff) begin
      nxt_resume_cnt = resume_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      resume_wait_ff <= 1'b0;
      resume_cnt_ff <= 16'h0000;
    end else begin
      resume_wait_ff <= nxt_resume_wait;
      resume_cnt_ff <= nxt_resume_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_sr_entry_cmd: assert property (
    state_ff == sr_hold_pkg::ST_ACTIVE && warm_reset_i && !warm_q_ff
    |=> cmd_o.op == sr_hold_pkg::OP_SRE && !cmd_o.cke
      && clk_change_ok_o)
    else $error("warm reset did not enter self-refresh");

  a_no_refresh_sr: assert property (
    !cmd_o.cke |-> cmd_o.op != sr_hold_pkg::OP_REF)
    else $error("refresh issued during self-refresh");

  a_refresh_issue: assert property (
    refresh_fire && state_ff == sr_hold_pkg::ST_ACTIVE && !warm_rise
    |=> cmd_o.op == sr_hold_pkg::OP_REF)
    else $error("elapsed interval gave no refresh");

  a_hold_keeps_sr: assert property (
    state_ff == sr_hold_pkg::ST_SELFREF && hold_ff
    |=> state_ff == sr_hold_pkg::ST_SELFREF)
    else $error("left self-refresh while hold set");

  a_hold_armed: assert property (
    hold_en_ff && warm_reset_i && !warm_q_ff
    && !wr_hit(wr_i, addr_i, sr_hold_pkg::REG_MISC) |=> hold_ff)
    else $error("hold not armed at warm reset");

  a_exit_cause: assert property (
    cmd_o.op == sr_hold_pkg::OP_SRX
    |-> $past(dur_done) && !$past(warm_reset_i) && !$past(hold_ff))
    else $error("self-refresh exit without its conditions");

  a_no_bypass_exit: assert property (
    cmd_o.op == sr_hold_pkg::OP_SRX |-> !$past(clk_bypass_i))
    else $error("self-refresh exit on bypass clock");

  a_clk_change_sr: assert property (
    clk_change_ok_o |-> !cmd_o.cke && state_ff == sr_hold_pkg::ST_SELFREF)
    else $error("clock change allowed outside self-refresh");

  a_refresh_resume: assert property (
    resume_wait_ff && cmd_o.op == sr_hold_pkg::OP_REF
    |-> resume_cnt_ff == interval_ff)
    else $error("first refresh after exit off its interval");

  a_sre_on_rise: assert property (
    cmd_o.op == sr_hold_pkg::OP_SRE
    |-> $past(warm_reset_i) && !$past(warm_q_ff))
    else $error("self-refresh entry without warm reset edge");

  a_no_ref_warm: assert property (
    warm_reset_i |=> cmd_o.op != sr_hold_pkg::OP_REF)
    else $error("refresh issued during warm reset");

  a_cke_low_sr: assert property (
    state_ff == sr_hold_pkg::ST_SELFREF |-> !cmd_o.cke)
    else $error("memory clock enabled while in self-refresh");

  a_exit_prompt: assert property (
    state_ff == sr_hold_pkg::ST_SELFREF && exit_ok
    |=> cmd_o.op == sr_hold_pkg::OP_SRX && cmd_o.cke)
    else $error("self-refresh not left once exit was allowed");

  c_warm_entry: cover property (
    cmd_o.op == sr_hold_pkg::OP_SRE);
  c_hold_exit: cover property (
    hold_ff ##1 !hold_ff ##[1:50] cmd_o.op == sr_hold_pkg::OP_SRX);
  c_plain_exit: cover property (
    !hold_en_ff && cmd_o.op == sr_hold_pkg::OP_SRX);
  c_refresh: cover property (cmd_o.op == sr_hold_pkg::OP_REF);
  c_ref_resume: cover property (
    resume_wait_ff && cmd_o.op == sr_hold_pkg::OP_REF);

endmodule

// ==== test/sdram_model.sv ====
// Behavioural external SDRAM that flags illegal command use.
`timescale 1ns/1ns
module sdram_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire sr_hold_pkg::sdram_cmd_t cmd_i,
  input wire logic bypass_i,
  output logic in_sr_o,
  output logic [7:0] err_o
);
  logic byp_d;
  // --------------------------------------------------------------
  // Command decode.
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_sr_o <= 1'b0;
      err_o <= 8'h00;
      byp_d <= 1'b0;
    end else begin
      byp_d <= bypass_i;
      if (cmd_i.op == sr_hold_pkg::OP_SRE) begin
        in_sr_o <= 1'b1;
      end
      if (cmd_i.op == sr_hold_pkg::OP_SRX) begin
        in_sr_o <= 1'b0;
        if (bypass_i) begin
          err_o <= err_o + 8'h01;
        end
      end
      // A refresh inside self-refresh is a controller fault.
      if (cmd_i.op == sr_hold_pkg::OP_REF && in_sr_o) begin
        err_o <= err_o + 8'h01;
      end
      // The clock may only change rate while the memory sleeps.
      if (bypass_i != byp_d && !in_sr_o) begin
        err_o <= err_o + 8'h01;
      end
    end
  end
endmodule

// ==== test/ddr_warm_reset_selfrefresh_hold_tb.sv ====
// Self-checking bench for the warm-reset self-refresh hold controller.
`timescale 1ns/1ns
module ddr_warm_reset_selfrefresh_hold_tb;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic warm_i = 1'b0;
  logic byp_i = 1'b0;
  sr_hold_pkg::sdram_cmd_t cmd_o;
  logic chg_ok_o;
  logic in_sr;
  logic [7:0] err;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;

  sr_hold_ctrl dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .warm_reset_i(warm_i), .clk_bypass_i(byp_i),
    .cmd_o(cmd_o), .clk_change_ok_o(chg_ok_o));
  sdram_model mem_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .cmd_i(cmd_o), .bypass_i(byp_i), .in_sr_o(in_sr), .err_o(err));

  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // --------------------------------------------------------------
  // Shared tasks.
  // --------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    // The whole run needs about 1000 cycles.
    if (cyc == 6000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", e, rdata_o);
  endtask
  task automatic wait_op(sr_hold_pkg::op_t op, output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      #1 k++;
    end while (cmd_o.op !== op && k < 400);
  endtask
  // Enter self-refresh, then drop to the bypass clock while asleep.
  task automatic enter_warm();
    @(posedge clk_i);
    warm_i <= 1'b1;
    wait_op(sr_hold_pkg::OP_SRE, n);
    chk("sre", 32'h1, 32'(n <= 2));
    chk("cke", 32'h0, 32'(cmd_o.cke));
    chk("chg_ok", 32'h1, 32'(chg_ok_o));
    @(posedge clk_i);
    byp_i <= 1'b1;
    rd(sr_hold_pkg::REG_STATUS, 32'h0000_000b);
    repeat (18) @(posedge clk_i);
    warm_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    byp_i <= 1'b0;
  endtask
  // --------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------
  task automatic t_regs();
    rd(sr_hold_pkg::REG_REFRESH, 32'h0000_0c30);
    rd(sr_hold_pkg::REG_MISC, 32'h0000_0000);
    rd(sr_hold_pkg::REG_STATUS, 32'h0000_0004);
    rd(8'h0c, 32'h0000_0000);
  endtask
  task automatic t_refresh();
    wr(sr_hold_pkg::REG_REFRESH, 32'h0000_000a);
    wait_op(sr_hold_pkg::OP_REF, n);
    wait_op(sr_hold_pkg::OP_REF, n);
    wait_op(sr_hold_pkg::OP_REF, n);
    chk("ref_gap", 32'd10, 32'(n));
    // A zero interval stops refresh, so the wait runs to its limit.
    wr(sr_hold_pkg::REG_REFRESH, 32'h0000_0000);
    wait_op(sr_hold_pkg::OP_REF, n);
    chk("ref_off", 32'd400, 32'(n));
    wr(sr_hold_pkg::REG_REFRESH, 32'h0000_000a);
  endtask
  task automatic t_nohold();
    enter_warm();
    wait_op(sr_hold_pkg::OP_SRX, n);
    n = n + 32;
    chk("srx_at", 32'h1, 32'(n >= sr_hold_pkg::WARM_CYCLES - 2
      && n <= sr_hold_pkg::WARM_CYCLES + 3));
    chk("cke_up", 32'h1, 32'(cmd_o.cke));
  endtask
  task automatic t_hold();
    wr(sr_hold_pkg::REG_MISC, 32'h0000_0040);
    enter_warm();
    repeat (250) @(posedge clk_i);
    #1 chk("held", 32'h0, 32'(cmd_o.cke));
    rd(sr_hold_pkg::REG_STATUS, 32'h0000_0005);
    rd(sr_hold_pkg::REG_MISC, 32'h0000_0060);
    // The clock is already back at full rate before the release.
    wr(sr_hold_pkg::REG_MISC, 32'h0000_0040);
    wait_op(sr_hold_pkg::OP_SRX, n);
    chk("srx_soon", 32'h1, 32'(n <= 3));
    wait_op(sr_hold_pkg::OP_REF, n);
    chk("ref_first", 32'd11, 32'(n));
    wait_op(sr_hold_pkg::OP_REF, n);
    chk("ref_again", 32'd10, 32'(n));
  endtask
  // Warm reset routed to the cold reset pin, which resets the memory too.
  task automatic t_cold();
    enter_warm();
    #1 chk("mem_sr", 32'h1, 32'(in_sr));
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1 chk("mem_lost", 32'h0, 32'(in_sr));
    chk("cke_rst", 32'h1, 32'(cmd_o.cke));
    chk("chg_rst", 32'h0, 32'(chg_ok_o));
    rd(sr_hold_pkg::REG_MISC, 32'h0000_0000);
    rd(sr_hold_pkg::REG_REFRESH, 32'h0000_0c30);
    rd(sr_hold_pkg::REG_STATUS, 32'h0000_0004);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_regs();
    t_refresh();
    t_nohold();
    t_hold();
    // The memory's error count is cleared by the cold reset that follows.
    chk("sdram_err", 32'h0, 32'(err));
    t_cold();
    close_out();
  end
endmodule
